// >>> verilog/sfh_host.sv
// master end of the slave fifo port: drives select, strobes, data bus
// assumes the port's interface clock arrives on a pin; it and the data bus are sampled
module sfh_host #(
  parameter int unsigned DEPTH = sfh_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // user side
  input wire logic sync_mode_i,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic [1:0] cmd_op_i,
  input wire logic [sfh_pkg::ADDR_W-1:0] cmd_addr_i,
  input wire logic [sfh_pkg::DATA_W-1:0] wr_data_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  output logic [sfh_pkg::DATA_W-1:0] rd_data_o,
  output logic rd_valid_o,
  output logic busy_o,
  // port side
  input wire logic interface_clock_i,
  output logic [sfh_pkg::ADDR_W-1:0] fifo_select_address_o,
  output logic port_chip_select_n_o,
  output logic fifo_output_enable_n_o,
  output logic fifo_read_strobe_n_o,
  output logic fifo_write_strobe_n_o,
  output logic packet_commit_strobe_n_o,
  input wire logic [sfh_pkg::DATA_W-1:0] fifo_data_bus_i,
  output logic [sfh_pkg::DATA_W-1:0] fifo_data_bus_o,
  output logic fifo_data_bus_oe_o
);
  localparam int unsigned DW = sfh_pkg::DATA_W;

  // ****************************************************************
  // write buffer in the data path
  // ****************************************************************
  sfh_stream_if #(.W(DW)) wr_in ();
  sfh_stream_if #(.W(DW)) wr_out ();
  assign wr_in.valid = wr_valid_i;
  assign wr_in.data = wr_data_i;
  assign wr_ready_o = wr_in.ready;

  sfh_fifo #(.WIDTH(DW), .DEPTH(DEPTH)) u_wbuf (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .in_s(wr_in.snk),
    .out_s(wr_out.src)
  );

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic ifc_m_q, ifc_s_q, ifc_p_q;
  logic [DW-1:0] din_m_q, din_s_q;
  logic ifc_rise;
  // first stage feeds only the second; edge found on the second stage
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ifc_m_q <= 1'b0;
      ifc_s_q <= 1'b0;
      ifc_p_q <= 1'b0;
      din_m_q <= '0;
      din_s_q <= '0;
    end else begin
      ifc_m_q <= interface_clock_i;
      ifc_s_q <= ifc_m_q;
      ifc_p_q <= ifc_s_q;
      din_m_q <= fifo_data_bus_i;
      din_s_q <= din_m_q;
    end
  end
  assign ifc_rise = ifc_s_q && !ifc_p_q;

  // ****************************************************************
  // transfer sequencer
  // ****************************************************************
  sfh_pkg::sfh_state_t st_q, st_d;
  logic [1:0] op_q, op_d;
  logic [sfh_pkg::ADDR_W-1:0] adr_q, adr_d;
  logic [3:0] cnt_q, cnt_d;
  logic cs_q, cs_d, oe_q, oe_d, rd_q, rd_d, wr_q, wr_d, pe_q, pe_d;
  logic drv_q, drv_d, rv_q, rv_d;
  logic [DW-1:0] dout_q, dout_d, rdat_q, rdat_d;
  logic take, pop;

  assign take = cmd_valid_i && (st_q == sfh_pkg::SFH_IDLE)
    && (cmd_op_i != 2'(sfh_pkg::SFH_CMD_WRITE) || wr_out.valid);
  assign cmd_ready_o = take;
  assign wr_out.ready = pop;

  // next state; steps count system cycles, sync also waits for an edge to start and end the strobe
  always_comb begin
    st_d = st_q;
    op_d = op_q;
    adr_d = adr_q;
    cnt_d = cnt_q;
    cs_d = cs_q;
    oe_d = oe_q;
    rd_d = rd_q;
    wr_d = wr_q;
    pe_d = pe_q;
    drv_d = drv_q;
    dout_d = dout_q;
    rdat_d = rdat_q;
    rv_d = 1'b0;
    pop = 1'b0;
    case (st_q)
      sfh_pkg::SFH_IDLE: begin
        if (take) begin
          // address and select go out first, held through the strobe
          op_d = cmd_op_i;
          adr_d = cmd_addr_i;
          cs_d = 1'b1;
          cnt_d = 4'(sfh_pkg::ADDR_SETUP_CYC);
          st_d = sfh_pkg::SFH_SETUP;
          if (cmd_op_i == 2'(sfh_pkg::SFH_CMD_WRITE)) begin
            dout_d = wr_out.data;
            drv_d = 1'b1;
            pop = 1'b1;
          end
          if (cmd_op_i == 2'(sfh_pkg::SFH_CMD_READ)) begin
            oe_d = 1'b1;
          end
        end
      end
      sfh_pkg::SFH_SETUP: begin
        if (cnt_q != sfh_pkg::CNT_ZERO) begin
          cnt_d = cnt_q - sfh_pkg::CNT_ONE;
        end else if (!sync_mode_i || ifc_rise) begin
          // strobes change just after an edge so the next edge samples them
          rd_d = (op_q == 2'(sfh_pkg::SFH_CMD_READ));
          wr_d = (op_q == 2'(sfh_pkg::SFH_CMD_WRITE));
          pe_d = (op_q == 2'(sfh_pkg::SFH_CMD_COMMIT));
          // sync read keeps the prefetched word: once the strobe edge
          // moves the device pointer, the bus already shows the next one
          if (sync_mode_i && op_q == 2'(sfh_pkg::SFH_CMD_READ)) begin
            rdat_d = din_s_q;
          end
          cnt_d = 4'(sfh_pkg::STROBE_LOW_CYC);
          st_d = sfh_pkg::SFH_STROBE;
        end
      end
      sfh_pkg::SFH_STROBE: begin
        if (sync_mode_i) begin
          if (ifc_rise) begin
            st_d = sfh_pkg::SFH_HOLD;
            cnt_d = 4'(sfh_pkg::ASYNC_DATA_CYC);
          end
        end else if (cnt_q != sfh_pkg::CNT_ZERO) begin
          cnt_d = cnt_q - sfh_pkg::CNT_ONE;
        end else begin
          if (rd_q) begin
            rdat_d = din_s_q;
            rv_d = 1'b1;
          end
          rd_d = 1'b0;
          wr_d = 1'b0;
          pe_d = 1'b0;
          cnt_d = 4'(sfh_pkg::WR_HIGH_CYC);
          st_d = sfh_pkg::SFH_RECOVER;
        end
      end
      sfh_pkg::SFH_HOLD: begin
        // sync: drop strobes, wait a little, then hand the held word over
        rd_d = 1'b0;
        wr_d = 1'b0;
        pe_d = 1'b0;
        if (cnt_q != sfh_pkg::CNT_ZERO) begin
          cnt_d = cnt_q - sfh_pkg::CNT_ONE;
        end else begin
          if (op_q == 2'(sfh_pkg::SFH_CMD_READ)) begin
            rv_d = 1'b1;
          end
          cnt_d = 4'(sfh_pkg::WR_HIGH_CYC);
          st_d = sfh_pkg::SFH_RECOVER;
        end
      end
      sfh_pkg::SFH_RECOVER: begin
        // drop select, enable and bus only after the inactive width
        if (cnt_q != sfh_pkg::CNT_ZERO) begin
          cnt_d = cnt_q - sfh_pkg::CNT_ONE;
        end else begin
          cs_d = 1'b0;
          oe_d = 1'b0;
          drv_d = 1'b0;
          st_d = sfh_pkg::SFH_IDLE;
        end
      end
      default: begin
        st_d = sfh_pkg::SFH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q <= sfh_pkg::SFH_IDLE;
      op_q <= 2'h0;
      adr_q <= '0;
      cnt_q <= 4'h0;
      cs_q <= 1'b0;
      oe_q <= 1'b0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      pe_q <= 1'b0;
      drv_q <= 1'b0;
      rv_q <= 1'b0;
      dout_q <= '0;
      rdat_q <= '0;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      adr_q <= adr_d;
      cnt_q <= cnt_d;
      cs_q <= cs_d;
      oe_q <= oe_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      pe_q <= pe_d;
      drv_q <= drv_d;
      rv_q <= rv_d;
      dout_q <= dout_d;
      rdat_q <= rdat_d;
    end
  end

  // ****************************************************************
  // pin drive, strobes active low
  // ****************************************************************
  // bus driven only for writes, never while output enable is asserted
  assign fifo_select_address_o = adr_q;
  assign port_chip_select_n_o = !cs_q;
  assign fifo_output_enable_n_o = !oe_q;
  assign fifo_read_strobe_n_o = !rd_q;
  assign fifo_write_strobe_n_o = !wr_q;
  assign packet_commit_strobe_n_o = !pe_q;
  assign fifo_data_bus_o = dout_q;
  assign fifo_data_bus_oe_o = drv_q && !oe_q;
  assign rd_data_o = rdat_q;
  assign rd_valid_o = rv_q;
  assign busy_o = (st_q != sfh_pkg::SFH_IDLE);
endmodule : sfh_host

// >>> common/sfh_pkg.sv
// package for the slave fifo host port (external master side)
// assumes a 100 MHz system clock and an active-low asynchronous reset
// Functional notes
// - address stable and port selected over a cycle before strobes
// - master asserts chip select no later than the read strobe
// - master asserts chip select no later than the write strobe
// - master keeps output enable asserted whenever it expects read data
// - sync write: master puts data on bus before the capturing edge
// - packet end may come with the last word or any later cycle
// - master keeps the address unchanged while packet end is asserted
// - one-word packet after auto commit: packet end a cycle later
// - master may tie read strobe and output enable together in async read
// - async write: master has data valid before write strobe deasserts
// - async mode: packet end only after write strobe inactive long enough
package sfh_pkg;
  // ****************************************************************
  // widths and counts
  // ****************************************************************
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned CLK_NS = 10;
  // ****************************************************************
  // timing: setup over a cycle at fastest clock, async pulse widths
  // ****************************************************************
  localparam int unsigned ADDR_SETUP_NS = 25;
  localparam int unsigned ADDR_SETUP_CYC =
    (ADDR_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned STROBE_LOW_NS = 50;
  localparam int unsigned STROBE_LOW_CYC =
    (STROBE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WR_HIGH_NS = 70;
  localparam int unsigned WR_HIGH_CYC = (WR_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned ASYNC_DATA_NS = 15;
  localparam int unsigned ASYNC_DATA_CYC =
    (ASYNC_DATA_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;

  // command codes from the user side
  typedef enum logic [1:0] {
    SFH_CMD_WRITE = 2'h0,
    SFH_CMD_READ = 2'h1,
    SFH_CMD_COMMIT = 2'h2
  } sfh_cmd_t;

  // usual path is gray coded: idle, setup, strobe, hold, release
  typedef enum logic [2:0] {
    SFH_IDLE = 3'h0,
    SFH_SETUP = 3'h1,
    SFH_STROBE = 3'h3,
    SFH_HOLD = 3'h2,
    SFH_RECOVER = 3'h6
  } sfh_state_t;
endpackage : sfh_pkg

// >>> common/sfh_stream_if.sv
// valid/ready word stream between the host port and its buffer
// assumes both ends run on the system clock
interface sfh_stream_if #(
  parameter int unsigned W = 16
);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : sfh_stream_if

// >>> verilog/sfh_fifo.sv
// synchronous word fifo with valid/ready on both sides
// assumes one clock and an active-low asynchronous reset
module sfh_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  sfh_stream_if.snk in_s,
  sfh_stream_if.src out_s
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  // ****************************************************************
  // handshake and pointers
  // ****************************************************************
  assign in_s.ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_s.valid = (cnt_q != '0);
  assign out_s.data = mem_q[rp_q];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  // next pointers and fill count
  always_comb begin
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = pop ? rp_q + 1'b1 : rp_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  // storage holds no reset so it maps onto ram
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_q[wp_q] <= in_s.data;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end
endmodule : sfh_fifo

// >>> verification/sfh_host_asserts.sv
// checker for the host end of the slave fifo port
// assumes it is bound to sfh_host and sees only its ports
module sfh_host_asserts (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic [sfh_pkg::ADDR_W-1:0] fifo_select_address_o,
  input wire logic port_chip_select_n_o,
  input wire logic fifo_output_enable_n_o,
  input wire logic fifo_read_strobe_n_o,
  input wire logic fifo_write_strobe_n_o,
  input wire logic packet_commit_strobe_n_o,
  input wire logic [sfh_pkg::DATA_W-1:0] fifo_data_bus_o,
  input wire logic fifo_data_bus_oe_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // active-high aliases keep the properties short
  wire cs = !port_chip_select_n_o;
  wire oe = !fifo_output_enable_n_o;
  wire rd = !fifo_read_strobe_n_o;
  wire wr = !fifo_write_strobe_n_o;
  wire pe = !packet_commit_strobe_n_o;
  logic [3:0] hi_q;
  logic [3:0] hi_d;
  // cycles since the write strobe went away, saturating at 15
  always_comb begin
    hi_d = wr ? 4'h0 : (hi_q == 4'hf ? hi_q : hi_q + 4'h1);
  end
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) hi_q <= 4'hf;
    else hi_q <= hi_d;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  sequence s_wr_low; wr [*5]; endsequence
  sequence s_pe_run; pe ##1 pe; endsequence
  addr_setup_a: assert property ($rose(rd || wr) |-> $past(cs, 3) &&
    $past(fifo_select_address_o, 3) == fifo_select_address_o)
    else $error("address or select not set up early enough");
  rd_cs_a: assert property (rd |-> cs) else $error("read unselected");
  wr_cs_a: assert property (wr |-> cs) else $error("write unselected");
  rd_oe_a: assert property (rd |-> oe && !fifo_data_bus_oe_o)
    else $error("read without output enable");
  wr_data_a: assert property (wr |-> fifo_data_bus_oe_o &&
    $stable(fifo_data_bus_o)) else $error("write data not held");
  wr_pulse_a: assert property ($rose(wr) |-> s_wr_low)
    else $error("write strobe too short");
  pe_apart_a: assert property (pe |-> !wr && hi_q >= 4'h7)
    else $error("commit too close to write");
  pe_addr_a: assert property (s_pe_run |-> $stable(fifo_select_address_o))
    else $error("address moved during commit");
endmodule : sfh_host_asserts

bind sfh_host sfh_host_asserts sfh_host_asserts_i (.clk_sys_i, .resetn_i,
  .fifo_select_address_o, .port_chip_select_n_o, .fifo_output_enable_n_o,
  .fifo_read_strobe_n_o, .fifo_write_strobe_n_o, .packet_commit_strobe_n_o,
  .fifo_data_bus_o, .fifo_data_bus_oe_o);

// >>> verification/sfh_dev_model.sv
// behavioural model of the device side of the slave fifo port
// assumes active-low strobes; the bench resolves the shared data bus
module sfh_dev_model #(
  parameter int AUTO_LEN = 16 // words per auto-committed packet
) (
  input wire logic clk_i,
  input wire logic sync_i,
  input wire logic cs_n_i,
  input wire logic oe_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic pe_n_i,
  input wire logic [2:0] addr_i,
  input wire logic [15:0] bus_i,
  output logic interface_clock_o,
  output logic [15:0] data_o,
  output logic oe_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] q[8][$];
  logic [15:0] show_q;
  int commits;
  int auto_commits = 0;
  int pend[8] = '{default: 0};
  // auto mode: a packet commits itself once it holds AUTO_LEN words
  task automatic store(input logic [15:0] w);
    q[addr_i].push_back(w);
    pend[addr_i]++;
    if (pend[addr_i] == AUTO_LEN) begin
      pend[addr_i] = 0;
      auto_commits++;
    end
  endtask : store
  // free-running interface clock, phase unrelated to the system clock
  initial begin
    interface_clock_o = 1'b0;
    commits = 0;
    show_q = 16'h0;
    #3.7;
    forever #62.5 interface_clock_o = ~interface_clock_o;
  end
  // select is the only qualifier, so a tied select works too
  wire sel = !cs_n_i;
  // async read: fresh word on the leading edge, pointer bumps on that same edge
  always @(negedge rd_n_i) if (!sync_i && sel && q[addr_i].size() > 0)
    show_q = q[addr_i].pop_front();
  // async write: trailing edge captures the bus
  always @(posedge wr_n_i) if (!sync_i && sel)
    store(bus_i);
  // sync transfers land on the rising interface clock
  always @(posedge interface_clock_o) if (sync_i && sel) begin
    if (!wr_n_i) store(bus_i);
    if (!rd_n_i && q[addr_i].size() > 0) void'(q[addr_i].pop_front());
  end
  // a manual commit closes whatever the packet holds
  always @(negedge pe_n_i) begin
    commits++;
    pend[addr_i] = 0;
  end
  // drive only under output enable; async keeps the last read word
  always @(negedge clk_i) begin
    oe_o <= !oe_n_i;
    data_o <= !sync_i ? show_q :
      (q[addr_i].size() > 0 ? q[addr_i][0] : 16'h0);
  end
endmodule : sfh_dev_model

// >>> verification/testbench.sv
// self-checking bench for the host end of the slave fifo port
// assumes the device model stands on the port side
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rstn, sync, cvalid, wvalid, cready, wready, rvalid, busy;
  logic interface_clock, cs_n, oe_n, rd_n, wr_n, pe_n, bus_oe, dev_oe;
  logic [1:0] cop;
  logic [2:0] caddr, addr;
  logic [15:0] wdata, rdata, bus_o, bus_w, bus_q, dev_data;
  logic [15:0] exp_q[$];
  logic [15:0] ref_q[$];
  int err_total, compares, seed, n;
  // an undriven bus shows a toggling pattern, never the last value
  assign bus_w = bus_oe ? bus_o : (dev_oe ? dev_data : ~bus_q);
  always @(posedge clk) bus_q <= bus_w;
  sfh_host sfh_host_i (.clk_sys_i(clk), .resetn_i(rstn),
    .sync_mode_i(sync), .cmd_valid_i(cvalid), .cmd_ready_o(cready),
    .cmd_op_i(cop), .cmd_addr_i(caddr), .wr_data_i(wdata),
    .wr_valid_i(wvalid), .wr_ready_o(wready), .rd_data_o(rdata),
    .rd_valid_o(rvalid), .busy_o(busy), .interface_clock_i(interface_clock),
    .fifo_select_address_o(addr), .port_chip_select_n_o(cs_n),
    .fifo_output_enable_n_o(oe_n), .fifo_read_strobe_n_o(rd_n),
    .fifo_write_strobe_n_o(wr_n), .packet_commit_strobe_n_o(pe_n),
    .fifo_data_bus_i(bus_w), .fifo_data_bus_o(bus_o),
    .fifo_data_bus_oe_o(bus_oe));
  sfh_dev_model sfh_dev_model_i (.clk_i(clk), .sync_i(sync), .cs_n_i(cs_n),
    .oe_n_i(oe_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .pe_n_i(pe_n),
    .addr_i(addr), .bus_i(bus_w), .interface_clock_o(interface_clock), .data_o(dev_data),
    .oe_o(dev_oe));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    compares++;
    if (got !== want) begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, got, want);
    end
  endtask : chk
  // one command: hold the request until taken, then wait for idle
  task automatic cmd(input logic [1:0] op);
    @(negedge clk);
    cvalid = 1'b1;
    cop = op;
    do @(posedge clk); while (cready !== 1'b1);
    @(negedge clk);
    cvalid = 1'b0;
    while (busy !== 1'b0) @(negedge clk);
  endtask : cmd
  task automatic give_verdict();
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  // each returned word is matched against the oldest expectation;
  // looked at mid-cycle, where the one-cycle pulse has settled
  always @(negedge clk) if (rvalid === 1'b1) begin
    if (exp_q.size() == 0) begin
      err_total++;
      $display("[ERR] %0t unexpected read word", $time);
    end
    else chk(rdata, exp_q.pop_front());
  end
  // main sequence: async pass, then sync pass
  initial begin
    seed = 38330;
    {rstn, sync, cvalid, wvalid, cop, caddr, wdata} = '0;
    {err_total, compares, bus_q} = '0;
    repeat (2) @(posedge clk);
    @(negedge clk) rstn = 1'b1;
    for (int m = 0; m < 2; m++) begin
      sync = m[0];
      caddr = 3'($random(seed));
      n = 0;
      // fill the write buffer until it refuses; ready only follows the
      // fill count, so a word is offered only when it will be taken
      repeat (18) begin
        @(negedge clk);
        wvalid = (wready === 1'b1);
        if (wvalid) begin
          n++;
          wdata = 16'($random(seed));
          ref_q.push_back(wdata);
        end
      end
      @(negedge clk) wvalid = 1'b0;
      chk(16'(n), 16'h0010);
      repeat (16) cmd(sfh_pkg::SFH_CMD_WRITE);
      cmd(sfh_pkg::SFH_CMD_COMMIT);
      repeat (16) begin
        exp_q.push_back(ref_q.pop_front());
        cmd(sfh_pkg::SFH_CMD_READ);
      end
    end
    repeat (20) @(negedge clk);
    chk(16'(exp_q.size()), 16'h0000);
    chk(16'(sfh_dev_model_i.commits), 16'h0002);
    chk(16'(sfh_dev_model_i.auto_commits), 16'h0002);
    give_verdict();
  end
  initial begin
    #400000;
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict();
  end
endmodule : testbench
